// ### common/hbm_pkg.sv
// constants for the host bus, modem status and interrupt pin block
// assumes the standard serial register layout at register_select values
package hbm_pkg;
  // serial register select values
  localparam logic [2:0] SER_DATA = 3'h0;
  localparam logic [2:0] SER_IER = 3'h1;
  localparam logic [2:0] SER_IIR = 3'h2;
  localparam logic [2:0] SER_LCR = 3'h3;
  localparam logic [2:0] SER_MCR = 3'h4;
  localparam logic [2:0] SER_LSR = 3'h5;
  localparam logic [2:0] SER_MSR = 3'h6;
  localparam logic [2:0] SER_SCR = 3'h7;
  // printer register select values
  localparam logic [2:0] PRN_DATA = 3'h0;
  localparam logic [2:0] PRN_STAT = 3'h1;
  localparam logic [2:0] PRN_CTRL = 3'h2;
  // modem status fields
  localparam int MSR_DCTS = 0;
  localparam int MSR_DDSR = 1;
  localparam int MSR_TERI = 2;
  localparam int MSR_DDCD = 3;
  localparam int MSR_CTS = 4;
  localparam int MSR_DSR = 5;
  localparam int MSR_RI = 6;
  localparam int MSR_DCD = 7;
  // modem control fields
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_IRQEN = 3;
  // interrupt enable fields
  localparam int IER_RDA = 0;
  localparam int IER_THRE = 1;
  localparam int IER_RLS = 2;
  localparam int IER_MS = 3;
  // printer fields
  localparam int PST_ACK = 2;
  localparam int PST_FAULT = 3;
  localparam int PCT_INIT = 2;
  localparam int PCT_IRQEN = 4;
  localparam logic [7:0] PCT_RESET = 8'h04;
  localparam logic [7:0] ZERO8 = 8'h00;
endpackage

// ### verification/hbm_printer_model.sv
// printer side model: acknowledge pulse and fault pin
// assumes ack requests arrive as one-cycle pulses on the system clock; the fault request is a level
`timescale 1ns/1ps
module hbm_printer_model #(
  parameter int ACK_LOW = 8
) (
  input wire logic clk_sys,
  input wire logic ackReq,
  input wire logic faultReq,
  output logic printerAcknowledgeN,
  output logic printerFaultN
);
  int cnt = 0;
  always @(posedge clk_sys) begin
    if (ackReq) cnt <= ACK_LOW;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  assign printerAcknowledgeN = (cnt == 0);
  assign printerFaultN = ~faultReq;
endmodule

// ### verification/host_bus_modem_irq_pins_test.sv
// self-checking bench for the host bus, modem and interrupt pins
// assumes a printer model on the far side; host and modems driven here
`timescale 1ns/1ps
module host_bus_modem_irq_pins_test import hbm_pkg::*;;
  logic clk_sys = 0, rst = 1, rdS = 1, wrS = 1, ackReq = 0, faultReq = 0, modeSel = 0;
  logic dataOe, oeSeen, ackN, faultN, pIrq, pIrqOe, initO, initOe;
  logic [7:0] dataIn = 8'h00, dataOut, rd, v;
  logic [1:0] chan;
  logic [2:0] regSel = 3'h0, csN = 3'h7;
  logic [1:0] dcdN = 2'h3, dsrN = 2'h3, rxAvail = 2'h0, rxTaken = 2'h0, trN, rtsN, irqO, irqOe;
  int failures = 0, checks = 0, seed = 32'h7355;
  hbm_host_pins dut (.clk_sys(clk_sys), .rst(rst), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .registerSelect(regSel), .chipSelectN(csN), .ioReadStrobeN(rdS), .ioWriteStrobeN(wrS),
    .carrierDetectN(dcdN), .dataSetReadyN(dsrN), .clearToSendN(2'h3), .ringIndicatorN(2'h3),
    .rxDataAvail(rxAvail), .rxLineError(2'h0), .txHoldEmpty(2'h0), .txHoldFill(2'h0),
    .rxDataTaken(rxTaken), .terminalReadyN(trN), .requestToSendN(rtsN), .serialIrqOut(irqO),
    .serialIrqOe(irqOe), .printerAcknowledgeN(ackN), .printerFaultN(faultN),
    .printerIrqModeSelect(modeSel), .printerIrqOut(pIrq), .printerIrqOe(pIrqOe),
    .printerInitializeNOut(initO), .printerInitializeNOe(initOe));
  hbm_printer_model prn (.clk_sys(clk_sys), .ackReq(ackReq), .faultReq(faultReq),
    .printerAcknowledgeN(ackN), .printerFaultN(faultN));
  initial forever #2.5 clk_sys = ~clk_sys;
  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // cs 3 selects nothing; strobe held 6 cycles, select kept past the write edge
  task automatic access(input logic wr, input logic [1:0] cs, input logic [2:0] rs, input logic [7:0] d);
    csN = ~(3'h1 << cs);
    regSel = rs;
    dataIn = d;
    if (wr) wrS = 0;
    else rdS = 0;
    cyc(6);
    rd = dataOut;
    oeSeen = dataOe;
    wrS = 1;
    rdS = 1;
    cyc(5);
    csN = 3'h7;
    cyc(2);
  endtask
  function automatic logic [7:0] msrExp(input logic dcd, input logic dsr, input logic dd, input logic ds);
    return {~dcd, 1'b0, ~dsr, 1'b0, dd, 1'b0, ds, 1'b0};
  endfunction
  task automatic ackPulse(input int n);
    ackReq = 1;
    cyc(1);
    ackReq = 0;
    cyc(n);
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    complete_run;
  end
  initial begin
    cyc(3);
    rst = 0;
    check("trN", 8'h03, {6'h0, trN});
    check("irqOe", 8'h00, {6'h0, irqOe});
    check("pIrqOe", 8'h00, {7'h0, pIrqOe});
    check("dataOe", 8'h00, {7'h0, dataOe});
    cyc(4);
    // stale change flags from reset are flushed first
    access(0, 0, SER_MSR, 8'h00);
    access(0, 1, SER_MSR, 8'h00);
    for (int i = 0; i < 12; i++) begin
      v = (i < 8) ? (8'h01 << i) : 8'($random(seed));
      chan = 2'($random(seed) & 1);
      access(1, chan, SER_SCR, v);
      access(0, chan, SER_SCR, 8'h00);
      check("scratch", v, rd);
      check("readOe", 8'h01, {7'h0, oeSeen});
    end
    access(0, 3, SER_SCR, 8'h00);
    check("noSelOe", 8'h00, {7'h0, oeSeen});
    access(1, 0, SER_MCR, 8'h09);
    access(1, 1, SER_MCR, 8'h08);
    check("trN", 8'h02, {6'h0, trN});
    check("irqOe", 8'h03, {6'h0, irqOe});
    access(1, 0, SER_IER, 8'h08);
    dcdN[0] = 0;
    cyc(5);
    check("irqModem", 8'h01, {7'h0, irqO[0]});
    access(0, 0, SER_MSR, 8'h00);
    check("msr", msrExp(0, 1, 1, 0), rd);
    check("irqServed", 8'h00, {7'h0, irqO[0]});
    dsrN[0] = 0;
    dcdN[0] = 1;
    cyc(5);
    access(0, 0, SER_MSR, 8'h00);
    check("msr", msrExp(1, 0, 1, 1), rd);
    access(0, 0, SER_MSR, 8'h00);
    check("msr", msrExp(1, 0, 0, 0), rd);
    rxAvail[1] = 1;
    cyc(3);
    check("irqMasked", 8'h00, {7'h0, irqO[1]});
    access(1, 1, SER_IER, 8'h01);
    check("irqData", 8'h01, {7'h0, irqO[1]});
    rxAvail[1] = 0;
    rxTaken[1] = 1;
    cyc(1);
    rxTaken[1] = 0;
    cyc(2);
    check("irqData", 8'h00, {7'h0, irqO[1]});
    access(1, 2, PRN_CTRL, 8'h10);
    check("initOe", 8'h01, {7'h0, initOe});
    check("initOut", 8'h00, {7'h0, initO});
    access(1, 2, PRN_CTRL, 8'h14);
    check("initOe", 8'h00, {7'h0, initOe});
    check("pIrqOe", 8'h01, {7'h0, pIrqOe});
    ackPulse(5);
    check("pIrqDirect", 8'h00, {7'h0, pIrq});
    cyc(8);
    check("pIrqDirect", 8'h01, {7'h0, pIrq});
    modeSel = 1;
    faultReq = 1;
    access(0, 2, PRN_STAT, 8'h00);
    check("pstat", 8'h00, rd);
    check("pIrqLatch", 8'h00, {7'h0, pIrq});
    ackPulse(14);
    check("pIrqLatch", 8'h01, {7'h0, pIrq});
    cyc(20);
    check("pIrqHeld", 8'h01, {7'h0, pIrq});
    access(0, 2, PRN_STAT, 8'h00);
    check("pIrqLatch", 8'h00, {7'h0, pIrq});
    faultReq = 0;
    access(0, 2, PRN_STAT, 8'h00);
    check("pstat", 8'h0c, rd);
    rst = 1;
    cyc(3);
    rst = 0;
    check("trN", 8'h03, {6'h0, trN});
    check("irqOe", 8'h00, {6'h0, irqOe});
    check("pIrqOe", 8'h00, {7'h0, pIrqOe});
    check("initOe", 8'h00, {7'h0, initOe});
    complete_run;
  end
endmodule

// ### verilog/hbm_host_pins.sv
// host bus decode, modem status, modem control and interrupt pins
// assumes strobes, selects and modem/printer inputs are asynchronous pins;
// serial datapath events arrive as same-clock levels from the channel logic
`timescale 1ns/1ps
module hbm_host_pins
  import hbm_pkg::*;
#(
  parameter int NCHAN = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOe,
  input wire logic [2:0] registerSelect,
  input wire logic [2:0] chipSelectN,
  input wire logic ioReadStrobeN,
  input wire logic ioWriteStrobeN,
  input wire logic [NCHAN-1:0] carrierDetectN,
  input wire logic [NCHAN-1:0] dataSetReadyN,
  input wire logic [NCHAN-1:0] clearToSendN,
  input wire logic [NCHAN-1:0] ringIndicatorN,
  input wire logic [NCHAN-1:0] rxDataAvail,
  input wire logic [NCHAN-1:0] rxLineError,
  input wire logic [NCHAN-1:0] txHoldEmpty,
  input wire logic [NCHAN-1:0] txHoldFill,
  input wire logic [NCHAN-1:0] rxDataTaken,
  output logic [NCHAN-1:0] terminalReadyN,
  output logic [NCHAN-1:0] requestToSendN,
  output logic [NCHAN-1:0] serialIrqOut,
  output logic [NCHAN-1:0] serialIrqOe,
  input wire logic printerAcknowledgeN,
  input wire logic printerFaultN,
  input wire logic printerIrqModeSelect,
  output logic printerIrqOut,
  output logic printerIrqOe,
  output logic printerInitializeNOut,
  output logic printerInitializeNOe
);
  initial begin
    if (NCHAN != 2) $error("hbm_host_pins: exactly two serial channels served");
  end

  typedef struct packed {
    logic [1:0][8:0] pinS1;
    logic [1:0][8:0] pinS2;
    logic [1:0][3:0] modemPrev;
    logic rdPrev;
    logic wrPrev;
    logic [1:0][3:0] delta;
    logic [1:0][7:0] modem_control_reg;
    logic [1:0][3:0] ier;
    logic [1:0][7:0] scratch;
    logic [1:0] lsrRead;
    logic [1:0] iirThre;
    logic ackPrev;
    logic ackFlag;
    logic [7:0] pctrl;
    logic [7:0] rdData;
    logic rdActive;
  } hbm_state_s;

  hbm_state_s s_q;
  hbm_state_s s_d;

  // synchronised pins: strobes, selects, two ack/fault bits, modem inputs
  logic [8:0] rawA;
  logic [8:0] rawB;
  logic [8:0] pinA;
  logic [8:0] pinB;
  logic rdN;
  logic wrN;
  logic [2:0] csN;
  logic ackN;
  logic faultN;
  logic modeSel;
  logic [1:0][3:0] modem;
  logic rdRise;
  logic wrRise;
  logic [1:0] irqSrc;

  // mode strap is a pin too, so it goes through the same two stages
  assign rawA = {ioReadStrobeN, ioWriteStrobeN, chipSelectN, printerAcknowledgeN, printerFaultN,
    printerIrqModeSelect, 1'b0};
  assign rawB = {1'b0, carrierDetectN[1], dataSetReadyN[1], clearToSendN[1], ringIndicatorN[1],
    carrierDetectN[0], dataSetReadyN[0], clearToSendN[0], ringIndicatorN[0]};
  assign pinA = s_q.pinS2[0];
  assign pinB = s_q.pinS2[1];
  assign rdN = pinA[8];
  assign wrN = pinA[7];
  assign csN = pinA[6:4];
  assign ackN = pinA[3];
  assign faultN = pinA[2];
  assign modeSel = pinA[1];
  // modem nibble per channel: dcd, dsr, cts, ri (true levels)
  assign modem[1] = ~pinB[7:4];
  assign modem[0] = ~pinB[3:0];
  // completed strobe = rising edge of the synchronised strobe
  assign rdRise = rdN & ~s_q.rdPrev;
  assign wrRise = wrN & ~s_q.wrPrev;

  always_comb begin
    logic [7:0] rd;
    logic [3:0] chg;
    logic [3:0] tog;
    rd = ZERO8;
    chg = 4'h0;
    tog = 4'h0;
    s_d = s_q;
    s_d.pinS1[0] = rawA;
    s_d.pinS1[1] = rawB;
    s_d.pinS2 = s_q.pinS1;
    s_d.rdPrev = rdN;
    s_d.wrPrev = wrN;
    s_d.ackPrev = ackN;
    for (int c = 0; c < 2; c++) begin
      s_d.modemPrev[c] = modem[c];
      // dcd change flag, set wins over the read clear
      // dsr change flag, same set-over-clear
      // nibble is dcd,dsr,cts,ri; regroup into delta order dcd,ri rise,dsr,cts
      tog = modem[c] ^ s_q.modemPrev[c];
      chg = {tog[3], modem[c][0] & ~s_q.modemPrev[c][0], tog[2], tog[1]};
      if (rdRise && !csN[c] && registerSelect == SER_MSR) begin
        s_d.delta[c] = chg;
      end else begin
        s_d.delta[c] = s_q.delta[c] | chg;
      end
      // thre interrupt cleared by iir read, set again on any cycle the tx holding register is empty
      if (txHoldFill[c]) begin
        s_d.iirThre[c] = 1'b0;
      end else if (txHoldEmpty[c] && !s_q.iirThre[c] && !(rdRise && !csN[c] && registerSelect == SER_IIR)) begin
        s_d.iirThre[c] = 1'b1;
      end
      if (rdRise && !csN[c] && registerSelect == SER_IIR && !rxLineError[c] && !rxDataAvail[c]) begin
        s_d.iirThre[c] = 1'b0;
      end
      if (wrRise && !csN[c]) begin
        case (registerSelect)
          SER_IER: s_d.ier[c] = dataIn[3:0];
          SER_MCR: s_d.modem_control_reg[c] = {3'b000, dataIn[4:0]};
          SER_SCR: s_d.scratch[c] = dataIn;
          default: s_d.scratch[c] = s_q.scratch[c];
        endcase
      end
    end
    // direct mode follows the ack level; ack rise latched in either mode, used in flag mode
    // status read clears flag, but a fresh rise wins
    if (ackN && !s_q.ackPrev) begin
      s_d.ackFlag = 1'b1;
    end else if (rdRise && !csN[2] && registerSelect == PRN_STAT) begin
      s_d.ackFlag = 1'b0;
    end
    if (wrRise && !csN[2] && registerSelect == PRN_CTRL) begin
      s_d.pctrl = dataIn;
    end
    // read mux, captured while the strobe is low
    if (!csN[0] || !csN[1]) begin
      for (int c = 0; c < 2; c++) begin
        if (!csN[c]) begin
          case (registerSelect)
            SER_IER: rd = {4'h0, s_q.ier[c]};
            SER_IIR: rd = {7'h00, ~irqSrc[c]};
            SER_MCR: rd = s_q.modem_control_reg[c];
            SER_LSR: rd = {1'b0, txHoldEmpty[c], txHoldEmpty[c], 4'h0, rxDataAvail[c]};
            // dcd in bit 7; dsr in bit 5
            SER_MSR: rd = {modem[c][3], modem[c][0], modem[c][2], modem[c][1], s_q.delta[c]};
            SER_SCR: rd = s_q.scratch[c];
            default: rd = ZERO8;
          endcase
        end
      end
    end else if (!csN[2]) begin
      case (registerSelect)
        PRN_STAT: begin
          rd[PST_FAULT] = faultN;
          rd[PST_ACK] = ~s_q.ackFlag;
        end
        PRN_CTRL: rd = s_q.pctrl;
        default: rd = ZERO8;
      endcase
    end
    s_d.rdActive = !rdN && (csN != 3'b111);
    if (!rdN) begin
      s_d.rdData = rd;
    end
    // reset clears modem control and loads printer control with PCT_RESET
    if (rst) begin
      s_d = '0;
      s_d.pinS1[0] = {5'h1f, 4'hf};
      s_d.pinS2[0] = {5'h1f, 4'hf};
      // idle modem pins are high, so no false change after reset
      s_d.pinS1[1] = 9'h0ff;
      s_d.pinS2[1] = 9'h0ff;
      s_d.rdPrev = 1'b1;
      s_d.wrPrev = 1'b1;
      s_d.ackPrev = 1'b1;
      s_d.pctrl = PCT_RESET;
    end
  end

  always_ff @(posedge clk_sys) begin
    s_q <= s_d;
  end

  // any enabled source raises the channel interrupt
  // sources clear on service (msr read, iir read, data taken); line error follows rxLineError
  // carrier detect reaches only the modem status path
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      irqSrc[c] = (s_q.ier[c][IER_RLS] & rxLineError[c])
        | (s_q.ier[c][IER_RDA] & rxDataAvail[c] & ~rxDataTaken[c])
        | (s_q.ier[c][IER_THRE] & s_q.iirThre[c])
        | (s_q.ier[c][IER_MS] & (|s_q.delta[c]));
    end
  end

  // bus driven only while a read is selected; bit 0 is lsb
  assign dataOut = s_q.rdData;
  assign dataOe = s_q.rdActive;
  // terminal ready low while control bit 0 set
  assign terminalReadyN = {~s_q.modem_control_reg[1][MCR_DTR], ~s_q.modem_control_reg[0][MCR_DTR]};
  assign requestToSendN = {~s_q.modem_control_reg[1][MCR_RTS], ~s_q.modem_control_reg[0][MCR_RTS]};
  // output enable from control bit 3
  assign serialIrqOut = irqSrc;
  assign serialIrqOe = {s_q.modem_control_reg[1][MCR_IRQEN], s_q.modem_control_reg[0][MCR_IRQEN]};
  // direct mode follows acknowledge; latched mode uses flag
  assign printerIrqOut = modeSel ? s_q.ackFlag : ackN;
  // enable from printer control bit 4
  assign printerIrqOe = s_q.pctrl[PCT_IRQEN];
  // open drain, only ever pulls low
  assign printerInitializeNOut = 1'b0;
  assign printerInitializeNOe = ~s_q.pctrl[PCT_INIT];

  // a dcd toggle shows in bit 3 within three cycles
  dcd_change_a: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(s_q.pinS2[1][3]) |-> ##[1:3] s_q.delta[0][MSR_DDCD])
    else $error("dcd change not flagged");
  dsr_change_a: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(s_q.pinS2[1][2]) |-> ##[1:3] s_q.delta[0][MSR_DDSR])
    else $error("dsr change not flagged");
  dtr_pin_a: assert property (@(posedge clk_sys) disable iff (rst)
    terminalReadyN[0] == !s_q.modem_control_reg[0][MCR_DTR]) else $error("dtr mismatch");
  ser_irq_oe_a: assert property (@(posedge clk_sys) disable iff (rst)
    wrRise && !csN[0] && registerSelect == SER_MCR |=> serialIrqOe[0] == $past(dataIn[3]))
    else $error("serial irq enable wrong");
  bus_release_a: assert property (@(posedge clk_sys) disable iff (rst)
    rdN |=> !dataOe) else $error("bus driven outside read");
  ack_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    rdRise && !csN[2] && registerSelect == PRN_STAT && !(ackN && !s_q.ackPrev) |=> !s_q.ackFlag)
    else $error("ack flag not cleared");
  ack_latch_a: assert property (@(posedge clk_sys) disable iff (rst)
    modeSel && ackN && !s_q.ackPrev |=> printerIrqOut) else $error("ack not latched");
  reset_mcr_a: assert property (@(posedge clk_sys)
    rst |=> terminalReadyN == 2'b11 && serialIrqOe == 2'b00 && !printerIrqOe)
    else $error("reset did not clear control");
  dcd_state_a: assert property (@(posedge clk_sys) disable iff (rst)
    rdN ##1 !rdN && !csN[0] && registerSelect == SER_MSR && $stable(modem[0]) |=> dataOut[7] == $past(modem[0][3]))
    else $error("dcd status bit wrong");
  dsr_state_a: assert property (@(posedge clk_sys) disable iff (rst)
    !rdN && !csN[0] && csN[1] && registerSelect == SER_MSR |=> dataOut[MSR_DSR] == $past(modem[0][2]))
    else $error("dsr status bit wrong");
  // msr read with no new change clears the dcd flag
  msr_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    rdRise && !csN[0] && registerSelect == SER_MSR && $stable(modem[0]) |=> !s_q.delta[0][MSR_DDCD])
    else $error("dcd change flag not cleared");
  dsr_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    rdRise && !csN[1] && registerSelect == SER_MSR && $stable(modem[1]) |=> !s_q.delta[1][MSR_DDSR])
    else $error("dsr change flag not cleared");
  // enabled modem change drives the channel interrupt
  ser_irq_a: assert property (@(posedge clk_sys) disable iff (rst)
    s_q.ier[0][IER_MS] && s_q.delta[0][MSR_DDCD] |-> serialIrqOut[0])
    else $error("modem interrupt missing");
  // servicing the only source drops the interrupt
  irq_service_a: assert property (@(posedge clk_sys) disable iff (rst)
    rdRise && !csN[0] && registerSelect == SER_MSR && $stable(modem[0]) && s_q.ier[0] == 4'h8 && !wrRise
      |=> !serialIrqOut[0])
    else $error("interrupt not cleared by service");
  prn_direct_a: assert property (@(posedge clk_sys) disable iff (rst)
    !modeSel && $rose(ackN) |-> printerIrqOut)
    else $error("direct printer interrupt wrong");
  // latched flag holds until a status read
  ack_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    s_q.ackFlag && !(rdRise && !csN[2] && registerSelect == PRN_STAT) |=> s_q.ackFlag)
    else $error("printer flag dropped early");
  // interrupt enable from control bit 4
  prn_oe_a: assert property (@(posedge clk_sys) disable iff (rst)
    wrRise && !csN[2] && registerSelect == PRN_CTRL |=> printerIrqOe == $past(dataIn[PCT_IRQEN]))
    else $error("printer irq enable wrong");
  // initialize pulled low while control bit 2 is clear
  init_drive_a: assert property (@(posedge clk_sys) disable iff (rst)
    wrRise && !csN[2] && registerSelect == PRN_CTRL |=> printerInitializeNOe == !$past(dataIn[PCT_INIT]))
    else $error("initialize drive wrong");
  scratch_wr_a: assert property (@(posedge clk_sys) disable iff (rst)
    wrRise && !csN[1] && registerSelect == SER_SCR |=> s_q.scratch[1] == $past(dataIn))
    else $error("scratch write lost");
  scratch_rd_a: assert property (@(posedge clk_sys) disable iff (rst)
    !rdN && !csN[1] && csN[0] && registerSelect == SER_SCR |=> dataOut == $past(s_q.scratch[1]))
    else $error("scratch read wrong");
  // bus only driven after a selected read
  bus_drive_a: assert property (@(posedge clk_sys) disable iff (rst)
    dataOe |-> $past(rdN) == 1'b0 && $past(csN) != 3'b111)
    else $error("bus driven without read");
  ser_irq_oe1_a: assert property (@(posedge clk_sys) disable iff (rst)
    wrRise && !csN[1] && registerSelect == SER_MCR |=> serialIrqOe[1] == $past(dataIn[3]))
    else $error("serial irq enable wrong");
endmodule
